// >>> rtl/emi_ext_mem_interface.sv
// External memory interface control-strobe and memory-clock generator
`timescale 1ns/10ps
module emi_ext_mem_interface
   import emi_pkg::*;
(
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic clk_en,
   input wire logic block_clock_gate,
   input wire logic builtin_protocol_select,
   input wire logic sync_async_select,
   input wire logic data_16bit,
   input wire logic [1:0] ext_clock_divider,
   input wire logic [2:0] read_extra_waits,
   input wire logic [2:0] write_extra_waits,
   input wire logic ext_mem_powerdown,
   input wire logic [17:0] port_role_select,
   input wire logic [5:0] port_override_reg,
   input wire logic hub_req,
   input wire logic hub_wr,
   input wire logic udb_ready,
   output logic hub_ack_q,
   output logic em_clock_q,
   output logic em_ce_n_q,
   output logic em_oe_n_q,
   output logic em_we_n_q,
   output logic em_adsc_n_q,
   output logic mem_sleep_signal_q,
   output logic xmem_rd_q,
   output logic xmem_wr_q,
   output logic [5:0] port_addr_latch_q,
   output logic [5:0] port_data_latch_q,
   output logic [5:0] port_ctrl_drive_q
);

   // ------------------------------------------------------------
   // Per-port role decode
   // ------------------------------------------------------------
   wire logic [5:0] is_addr;
   wire logic [5:0] is_data;
   wire logic [5:0] is_ctrl;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_PORTS; gi++) begin : g_port
         wire logic [2:0] role;
         assign role = port_role_select[gi*ROLE_W +: ROLE_W];
         // Three address byte roles
         assign is_addr[gi] = (role == ROLE_ADDR_MSB) |
                              (role == ROLE_ADDR_MID) |
                              (role == ROLE_ADDR_LSB);
         // Upper data byte only in 16-bit mode
         assign is_data[gi] = (role == ROLE_DATA_LSB) |
                              ((role == ROLE_DATA_MSB) &
                               data_16bit);
         // Pins driven only with role and override both set
         assign is_ctrl[gi] = (role == ROLE_CTRL) &
                              port_override_reg[gi];
      end
   endgenerate

   // ------------------------------------------------------------
   // Memory clock divider
   // ------------------------------------------------------------
   logic [1:0] mclk_cnt_q;
   logic [1:0] mclk_cnt_d;
   wire logic [2:0] div_n;
   wire logic [2:0] half_n;
   wire logic em_clock_d;

   assign div_n = {1'b0, ext_clock_divider} + 3'h1;
   assign half_n = div_n >> 1;
   assign mclk_cnt_d = (mclk_cnt_q >= ext_clock_divider) ?
                       MCLK_CNT_RST : mclk_cnt_q + 2'h1;
   // Divide by one: level is a gate for the pad clock
   assign em_clock_d = (ext_clock_divider == 2'h0) |
                       ({1'b0, mclk_cnt_d} < half_n);

   // ------------------------------------------------------------
   // Access length and wake time
   // ------------------------------------------------------------
   wire logic [3:0] two_n;
   wire logic [3:0] rd_total;
   wire logic [3:0] wr_total;
   wire logic [3:0] wake_total;
   wire logic [3:0] sync_len;

   assign two_n = {div_n, 1'b0};
   assign rd_total = two_n - RD_BASE_SUB +
                     {1'b0, read_extra_waits};
   assign wr_total = two_n - WR_BASE_SUB +
                     {1'b0, write_extra_waits};
   assign wake_total = 4'(WAKE_MEMCLKS * {1'b0, div_n});
   assign sync_len = {1'b0, div_n};

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   emi_state_t state_q;
   emi_state_t state_d;
   logic [3:0] cnt_q;
   logic [3:0] cnt_d;
   logic wr_q;
   logic wr_d;
   logic sleep_d;

   wire logic active;
   wire logic start;
   wire logic [3:0] total;
   wire logic builtin_end;
   wire logic custom_end;
   wire logic acc_end;

   assign active = block_clock_gate;
   assign start = (state_q == EMI_IDLE) & hub_req &
                  ~ext_mem_powerdown & ~mem_sleep_signal_q;
   assign total = wr_q ? wr_total : rd_total;
   assign builtin_end = builtin_protocol_select & (cnt_q >= total);
   assign custom_end = ~builtin_protocol_select & udb_ready;
   assign acc_end = (state_q == EMI_ACCESS) &
                    (builtin_end | custom_end);

   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      wr_d = wr_q;
      sleep_d = mem_sleep_signal_q;
      case (state_q)
         EMI_IDLE: begin
            cnt_d = CNT_RST;
            if (ext_mem_powerdown) begin
               // Only idle reaches here, so transfers finish first
               sleep_d = 1'b1;
            end else if (mem_sleep_signal_q) begin
               sleep_d = 1'b0;
               state_d = EMI_WAKE;
            end else if (start) begin
               wr_d = hub_wr;
               state_d = EMI_ACCESS;
            end
         end
         EMI_WAKE: begin
            cnt_d = cnt_q + 4'h1;
            if (cnt_q + 4'h1 >= wake_total) begin
               cnt_d = CNT_RST;
               state_d = EMI_IDLE;
            end
         end
         EMI_ACCESS: begin
            cnt_d = cnt_q + 4'h1;
            if (acc_end) begin
               cnt_d = CNT_RST;
               state_d = EMI_DONE;
            end
         end
         EMI_DONE: begin
            state_d = EMI_IDLE;
         end
         default: begin
            state_d = EMI_IDLE;
         end
      endcase
      if (!active) begin
         state_d = EMI_IDLE;
         cnt_d = CNT_RST;
         sleep_d = 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Strobe decode
   // ------------------------------------------------------------
   wire logic in_acc;
   wire logic first_clk;
   wire logic bi;
   wire logic sync_m;
   wire logic ce_n_d;
   wire logic oe_n_d;
   wire logic we_n_d;
   wire logic adsc_n_d;
   wire logic go;
   wire logic [5:0] addr_latch_d;
   wire logic [5:0] data_latch_d;

   assign go = (state_d == EMI_ACCESS) & (state_q == EMI_IDLE);
   assign in_acc = (state_d == EMI_ACCESS) & active;
   assign first_clk = go | (cnt_d < sync_len);
   assign bi = builtin_protocol_select;
   assign sync_m = sync_async_select;
   // Custom mode leaves strobes to user logic
   assign ce_n_d = ~(bi & in_acc);
   assign oe_n_d = ~(bi & in_acc & ~wr_d);
   assign we_n_d = ~(bi & in_acc & wr_d &
                     (~sync_m | first_clk));
   assign adsc_n_d = ~(bi & in_acc & sync_m & first_clk);
   // Ports latch address at start and data at write start or read end
   assign addr_latch_d = {NUM_PORTS{go & active}} & is_addr;
   assign data_latch_d = {NUM_PORTS{active &
                          ((go & hub_wr) | (acc_end & ~wr_q))}} &
                         is_data;

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= EMI_IDLE;
         cnt_q <= CNT_RST;
         wr_q <= 1'b0;
         mclk_cnt_q <= MCLK_CNT_RST;
         em_clock_q <= 1'b0;
      end else if (clk_en) begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         wr_q <= wr_d;
         mclk_cnt_q <= active ? mclk_cnt_d : MCLK_CNT_RST;
         em_clock_q <= active & em_clock_d;
      end
   end

   // Strobes out through the signal fabric to the control port
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         em_ce_n_q <= 1'b1;
         em_oe_n_q <= 1'b1;
         em_we_n_q <= 1'b1;
         em_adsc_n_q <= 1'b1;
         mem_sleep_signal_q <= 1'b0;
      end else if (clk_en) begin
         em_ce_n_q <= ce_n_d;
         em_oe_n_q <= oe_n_d;
         em_we_n_q <= we_n_d;
         em_adsc_n_q <= adsc_n_d;
         mem_sleep_signal_q <= sleep_d;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         hub_ack_q <= 1'b0;
         xmem_rd_q <= 1'b0;
         xmem_wr_q <= 1'b0;
         port_addr_latch_q <= '0;
         port_data_latch_q <= '0;
         port_ctrl_drive_q <= '0;
      end else if (clk_en) begin
         hub_ack_q <= acc_end & active;
         xmem_rd_q <= go & active & ~bi & ~hub_wr;
         xmem_wr_q <= go & active & ~bi & hub_wr;
         port_addr_latch_q <= addr_latch_d;
         port_data_latch_q <= data_latch_d;
         port_ctrl_drive_q <= is_ctrl & {NUM_PORTS{active}};
      end
   end

endmodule

// >>> rtl/emi_pkg.sv
// Constants shared by the external memory control-strobe generator
// ----------------------------------------------------------------
// Summary of operation
// - Only strobes; address and data bypass block
// - Memory clock is bus clock over 1..4
// - Four memory kinds, read and write
// - Up to 24 address bits, three ports
// - Data bus eight or sixteen bits wide
// - Role field picks address byte per port
// - Role field picks data byte per port
// - Control port needs role and override bit
// - Strobes leave via digital signal fabric
// - Built-in strobes or custom user logic protocol
// - Extra read waits added to every built-in mode read
// - Extra write waits added to every built-in mode write
// - Power-down drives memory sleep signal
// - Block clock gate turns interface on/off
// - Built-in mode: sync or async strobe style
// - Sleep waits for running transfer to end
// - Two memory clocks wake time after sleep
// - At most seven extra wait states
// ----------------------------------------------------------------
package emi_pkg;
   localparam int NUM_PORTS = 6;
   localparam int ROLE_W = 3;
   localparam int DIV_W = 2;
   localparam int WAIT_W = 3;
   localparam int CNT_W = 4;
   // Port role encodings
   localparam logic [2:0] ROLE_NONE = 3'h0;
   localparam logic [2:0] ROLE_ADDR_MSB = 3'h1;
   localparam logic [2:0] ROLE_ADDR_MID = 3'h2;
   localparam logic [2:0] ROLE_ADDR_LSB = 3'h3;
   localparam logic [2:0] ROLE_DATA_MSB = 3'h4;
   localparam logic [2:0] ROLE_DATA_LSB = 3'h5;
   localparam logic [2:0] ROLE_CTRL = 3'h6;
   // Base waits: read 2n-1, write 2n, n = divide factor
   localparam logic [3:0] RD_BASE_SUB = 4'h1;
   localparam logic [3:0] WR_BASE_SUB = 4'h0;
   localparam logic [3:0] WAKE_MEMCLKS = 4'h2;
   // Reset values
   localparam logic [1:0] MCLK_CNT_RST = 2'h0;
   localparam logic [3:0] CNT_RST = 4'h0;
   typedef enum logic [1:0] {
      EMI_IDLE,
      EMI_WAKE,
      EMI_ACCESS,
      EMI_DONE
   } emi_state_t;
endpackage

// >>> bench/emi_udb_model.sv
// Custom user-logic responder that ends each custom-mode transfer
`timescale 1ns/10ps
module emi_udb_model (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic xmem_rd_q,
   input wire logic xmem_wr_q,
   input wire logic [3:0] dly,
   output logic udb_ready
);
   logic [3:0] cnt_q;
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_q <= 4'h0;
         udb_ready <= 1'b0;
      end else begin
         udb_ready <= (cnt_q == 4'h1);
         if (xmem_rd_q || xmem_wr_q) begin
            cnt_q <= dly;
         end else if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
         end
      end
   end
endmodule

// >>> bench/emi_ext_mem_interface_assertions.sv
// Concurrent checks on the strobe generator ports
`timescale 1ns/10ps
module emi_ext_mem_interface_assertions
   import emi_pkg::*;
(
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic clk_en,
   input wire logic block_clock_gate,
   input wire logic builtin_protocol_select,
   input wire logic sync_async_select,
   input wire logic [1:0] ext_clock_divider,
   input wire logic [2:0] read_extra_waits,
   input wire logic [2:0] write_extra_waits,
   input wire logic [5:0] port_override_reg,
   input wire logic hub_ack_q,
   input wire logic em_ce_n_q,
   input wire logic em_oe_n_q,
   input wire logic em_we_n_q,
   input wire logic em_adsc_n_q,
   input wire logic mem_sleep_signal_q,
   input wire logic [5:0] port_ctrl_drive_q
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n || !clk_en);
   logic idle_w;
   assign idle_w = em_ce_n_q && em_oe_n_q && em_we_n_q && em_adsc_n_q;
   sequence s_wake;
      em_ce_n_q [*3];
   endsequence
   sequence s_rd1;
      !em_oe_n_q ##1 (hub_ack_q && em_oe_n_q);
   endsequence
   sequence s_wr1;
      !em_we_n_q [*2] ##1 (hub_ack_q && em_we_n_q);
   endsequence
   AST_GATE_OFF: assert property (!block_clock_gate |=> idle_w &&
      !hub_ack_q && port_ctrl_drive_q == 6'h00)
      else $error("strobes or ack while gated");
   AST_CTRL_OVR: assert property ($stable(port_override_reg) |->
      (port_ctrl_drive_q & ~port_override_reg) == 6'h00)
      else $error("control drive without override");
   AST_CE_ACK: assert property (builtin_protocol_select && hub_ack_q |->
      em_ce_n_q && $past(!em_ce_n_q)) else $error("ack not at end of CE");
   AST_CUSTOM: assert property (!builtin_protocol_select &&
      $past(!builtin_protocol_select) |-> idle_w)
      else $error("built-in strobes in custom mode");
   AST_ASYNC: assert property (!sync_async_select &&
      $past(!sync_async_select) |-> em_adsc_n_q)
      else $error("address strobe in async mode");
   AST_SLEEP: assert property ($rose(mem_sleep_signal_q) |->
      em_ce_n_q && $past(em_ce_n_q)) else $error("sleep during transfer");
   AST_WAKE: assert property ($fell(mem_sleep_signal_q) |-> s_wake)
      else $error("access inside wake time");
   AST_RD_T1: assert property ($fell(em_oe_n_q) &&
      ext_clock_divider == 2'h0 && read_extra_waits == 3'h0 |=> s_rd1)
      else $error("read length wrong");
   AST_WR_T2: assert property ($fell(em_we_n_q) && !sync_async_select &&
      ext_clock_divider == 2'h0 && write_extra_waits == 3'h0 |=> s_wr1)
      else $error("write length wrong");
endmodule
bind emi_ext_mem_interface emi_ext_mem_interface_assertions
   i_emi_ext_mem_interface_assertions (.*);

// >>> bench/emi_ext_mem_interface_test.sv
// Self-checking bench for the strobe generator
`timescale 1ns/10ps
`define CHK(nm, e, s) begin \
   cmp_count++; \
   if ((s) !== (e)) begin \
      error_cnt++; \
      $display("[FAIL] %s exp %0h got %0h", nm, e, s); \
   end \
end
module emi_ext_mem_interface_test;
   import emi_pkg::*;
   logic sys_clk = 1'b0, arst_n = 1'b0;
   logic gate = 1'b1, bis = 1'b1, sas = 1'b0, d16 = 1'b0, pd = 1'b0;
   logic req = 1'b0, wr = 1'b0;
   logic [1:0] div = 2'h0;
   logic [2:0] rx = 3'h0, wx = 3'h0;
   logic [3:0] dly = 4'h1;
   logic ack, mclk, ce_n, oe_n, we_n, adsc_n, slp, xrd, xwr, udb, ss;
   logic [5:0] al, dl, cd, sa, sd;
   int error_cnt = 0, cmp_count = 0, n;
   always #25 sys_clk = ~sys_clk;
   emi_ext_mem_interface i_emi_ext_mem_interface (
      .sys_clk(sys_clk), .arst_n(arst_n), .clk_en(1'b1),
      .block_clock_gate(gate), .builtin_protocol_select(bis),
      .sync_async_select(sas), .data_16bit(d16), .ext_clock_divider(div),
      .read_extra_waits(rx), .write_extra_waits(wx),
      .ext_mem_powerdown(pd), .port_role_select(18'h1195E),
      .port_override_reg(6'h03), .hub_req(req), .hub_wr(wr),
      .udb_ready(udb), .hub_ack_q(ack), .em_clock_q(mclk),
      .em_ce_n_q(ce_n), .em_oe_n_q(oe_n), .em_we_n_q(we_n),
      .em_adsc_n_q(adsc_n), .mem_sleep_signal_q(slp), .xmem_rd_q(xrd),
      .xmem_wr_q(xwr), .port_addr_latch_q(al), .port_data_latch_q(dl),
      .port_ctrl_drive_q(cd));
   emi_udb_model i_emi_udb_model (.sys_clk(sys_clk), .arst_n(arst_n),
      .xmem_rd_q(xrd), .xmem_wr_q(xwr), .dly(dly), .udb_ready(udb));
   task automatic results();
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // One access; lat 0 means no answer is expected
   task automatic xfer(input logic w, input int lat);
      sa = 6'h00;
      sd = 6'h00;
      ss = 1'b0;
      n = 0;
      @(posedge sys_clk);
      req <= 1'b1;
      wr <= w;
      for (int i = 1; i < 40 && n == 0; i++) begin
         @(posedge sys_clk);
         #1;
         sa |= al;
         sd |= dl;
         ss |= ~adsc_n;
         if (ack === 1'b1) n = i;
      end
      @(posedge sys_clk);
      req <= 1'b0;
      if (lat != 0 && n == 0) begin
         error_cnt++;
         results();
      end
   endtask
   task automatic t_reset();
      `CHK("idle", 5'h1E, {ce_n, oe_n, we_n, adsc_n, slp})
      `CHK("ctrl", 6'h01, cd)
   endtask
   task automatic t_timing();
      int t;
      for (int i = 0; i < 4; i++) begin
         for (int w = 0; w < 2; w++) begin
            @(posedge sys_clk);
            div <= 2'(i);
            rx <= 3'(i * 7 / 3);
            wx <= 3'(i * 7 / 3);
            sas <= i[0];
            d16 <= i[1];
            t = 2 * i + 1 + w + i * 7 / 3 + 2;
            xfer(w[0], t);
            `CHK("latency", t, n)
            `CHK("addr", 6'h32, sa)
            `CHK("data", i > 1 ? 6'h0C : 6'h04, sd)
            `CHK("adsc", i[0], ss)
         end
      end
   endtask
   task automatic t_custom();
      @(posedge sys_clk);
      bis <= 1'b0;
      for (int d = 1; d < 6; d += 4) begin
         dly <= 4'(d);
         xfer(1'(d > 1), d + 3);
         `CHK("custom", d + 3, n)
      end
      @(posedge sys_clk);
      bis <= 1'b1;
   endtask
   task automatic t_sleep();
      @(posedge sys_clk);
      div <= 2'h0;
      rx <= 3'h0;
      fork
         xfer(1'b0, 4);
         begin
            repeat (2) @(posedge sys_clk);
            pd <= 1'b1;
            repeat (2) @(posedge sys_clk);
            #1;
            `CHK("early sleep", 1'b0, slp)
         end
      join
      repeat (3) @(posedge sys_clk);
      #1;
      `CHK("sleep", 1'b1, slp)
      xfer(1'b0, 0);
      `CHK("asleep", 0, n)
      pd <= 1'b0;
      xfer(1'b0, 1);
      `CHK("wake", 5, n)
   endtask
   task automatic t_clock();
      int h, e;
      for (int i = 0; i < 4; i++) begin
         @(posedge sys_clk);
         div <= 2'(i);
         repeat (6) @(posedge sys_clk);
         h = 0;
         e = (i == 0) ? 12 : 12 / (i + 1) * ((i + 1) / 2);
         for (int k = 0; k < 12; k++) begin
            @(posedge sys_clk);
            #1;
            if (mclk === 1'b1) h++;
         end
         `CHK("mclk high", e, h)
      end
   endtask
   task automatic t_gate();
      fork
         xfer(1'b1, 0);
         begin
            repeat (2) @(posedge sys_clk);
            gate <= 1'b0;
         end
      join
      `CHK("abort", 0, n)
      `CHK("ctrl off", 6'h00, cd)
      `CHK("mclk off", 1'b0, mclk)
   endtask
   initial begin
      repeat (10) @(posedge sys_clk);
      arst_n <= 1'b1;
      @(posedge sys_clk);
      #1;
      t_reset();
      t_clock();
      t_timing();
      t_custom();
      t_sleep();
      t_gate();
      results();
   end
endmodule
